// ===== shared/lon_pkg.sv
// Package: encodings, field layout and types of the logical OR/NOR slice
package lon_pkg;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int unsigned FLD_OP_LSB = 0;
   localparam int unsigned FLD_OP_W = 6;
   localparam int unsigned FLD_IMM_LSB = 6;
   localparam int unsigned FLD_IMM_W = 16;
   localparam int unsigned FLD_XOP_LSB = 11;
   localparam int unsigned FLD_XOP_W = 6;
   localparam int unsigned FLD_C_LSB = 17;
   localparam int unsigned FLD_B_LSB = 22;
   localparam int unsigned FLD_A_LSB = 27;
   localparam int unsigned REG_IDX_W = 5;

   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [5:0] OP_RTYPE = 6'h3a;
   localparam logic [5:0] OP_ORHI = 6'h34;
   localparam logic [5:0] OP_ORI = 6'h14;
   localparam logic [5:0] OP_ADDI_UNUSED = 6'h04;
   localparam logic [5:0] XOP_NOR = 6'h06;
   localparam logic [5:0] XOP_OR = 6'h16;
   localparam logic [5:0] XOP_ADD = 6'h31;
   localparam logic [15:0] HALF_ZERO = 16'h0000;
   localparam logic [4:0] ZERO_REGISTER = 5'h00;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      LON_NONE = 3'b000,
      LON_NOR = 3'b001,
      LON_OR = 3'b011,
      LON_ORHI = 3'b010,
      LON_ORI = 3'b110,
      LON_NOP = 3'b111
   } lon_op_type;

   typedef struct packed {
      lon_op_type op;
      logic [4:0] first_source_register;
      logic [4:0] second_register_operand;
      logic [4:0] destination_register;
      logic [15:0] sixteen_bit_immediate;
   } lon_dec_type;

   typedef struct packed {
      logic valid;
      logic [4:0] index;
      logic [31:0] data;
   } lon_wb_type;

endpackage : lon_pkg

// ===== hdl/lon_decode.sv
// Decoder for the four logical instructions and the nop
`timescale 1ns/1ps
`default_nettype none
module lon_decode
   import lon_pkg::*;
(
   input wire logic [31:0] instr,
   output lon_dec_type dec
);

   logic [5:0] opc;
   logic [5:0] xop;

   assign opc = instr[FLD_OP_LSB +: FLD_OP_W];
   assign xop = instr[FLD_XOP_LSB +: FLD_XOP_W];

   always_comb begin
      dec.first_source_register = instr[FLD_A_LSB +: REG_IDX_W];
      dec.second_register_operand = instr[FLD_B_LSB +: REG_IDX_W];
      dec.sixteen_bit_immediate = instr[FLD_IMM_LSB +: FLD_IMM_W];
      dec.destination_register = instr[FLD_C_LSB +: REG_IDX_W];
      dec.op = LON_NONE;
      if (opc == OP_RTYPE) begin
         if (xop == XOP_NOR) begin
            dec.op = LON_NOR;
         end else if (xop == XOP_OR) begin
            dec.op = LON_OR;
         end else if (xop == XOP_ADD
                      && instr[FLD_C_LSB +: REG_IDX_W] == ZERO_REGISTER
                      && instr[FLD_B_LSB +: REG_IDX_W] == ZERO_REGISTER
                      && instr[FLD_A_LSB +: REG_IDX_W] == ZERO_REGISTER)
         begin
            dec.op = LON_NOP;
         end
      end else if (opc == OP_ORHI || opc == OP_ORI) begin
         dec.op = (opc == OP_ORHI) ? LON_ORHI : LON_ORI;
         dec.destination_register = instr[FLD_B_LSB +: REG_IDX_W];
      end
   end

endmodule : lon_decode
`default_nettype wire

// ===== hdl/lon_exec.sv
// Execution slice: register file and logical OR/NOR instructions
`timescale 1ns/1ps
`default_nettype none
module lon_exec
   import lon_pkg::*;
#(
   parameter int unsigned DATA_W = 32,
   parameter int unsigned NREGS = 32
)
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic instr_valid,
   input wire logic [31:0] instr,
   input wire logic [4:0] rd_index,
   output logic [DATA_W-1:0] rd_data,
   output logic wb_valid,
   output logic [4:0] wb_index,
   output logic [DATA_W-1:0] wb_data,
   output logic exc_q,
   output logic done_q
);

   lon_dec_type dec;
   logic [DATA_W-1:0] regs_q [NREGS];
   logic [DATA_W-1:0] src_a;
   logic [DATA_W-1:0] src_b;
   lon_wb_type wb_d;
   lon_wb_type wb_q;
   logic [DATA_W-1:0] rd_q;
   logic done_d;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   lon_decode u_dec (
      .instr(instr),
      .dec(dec)
   );

   assign src_a = regs_q[dec.first_source_register];
   assign src_b = regs_q[dec.second_register_operand];

   // ------------------------------------------------------------
   // Execute
   // ------------------------------------------------------------
   always_comb begin
      wb_d.valid = 1'b0;
      wb_d.index = dec.destination_register;
      wb_d.data = WORD_RESET;
      done_d = 1'b0;
      if (instr_valid) begin
         unique case (dec.op)
            LON_NOR: begin
               wb_d.data = ~(src_a | src_b);
               wb_d.valid = 1'b1;
            end
            LON_OR: begin
               wb_d.data = src_a | src_b;
               wb_d.valid = 1'b1;
            end
            LON_ORHI: begin
               wb_d.data = src_a | {dec.sixteen_bit_immediate, HALF_ZERO};
               wb_d.valid = 1'b1;
            end
            LON_ORI: begin
               wb_d.data = src_a | {HALF_ZERO, dec.sixteen_bit_immediate};
               wb_d.valid = 1'b1;
            end
            LON_NOP: begin
               wb_d.valid = 1'b0;
            end
            LON_NONE: begin
               wb_d.valid = 1'b0;
            end
         endcase
         done_d = (dec.op != LON_NONE);
      end
      if (wb_d.index == ZERO_REGISTER) begin
         wb_d.valid = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   // Zero register is never written, so it reads as zero from reset on
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int i = 0; i < NREGS; i++) begin
            regs_q[i] <= WORD_RESET;
         end
      end else if (wb_d.valid) begin
         regs_q[wb_d.index] <= wb_d.data;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wb_q <= '0;
         done_q <= 1'b0;
      end else begin
         wb_q <= wb_d;
         done_q <= done_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rd_q <= WORD_RESET;
      end else begin
         rd_q <= regs_q[rd_index];
      end
   end

   always_ff @(posedge mclk) begin
      exc_q <= 1'b0;
   end

   assign wb_valid = wb_q.valid;
   assign wb_index = wb_q.index;
   assign wb_data = wb_q.data;
   assign rd_data = rd_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_nor_result;
      @(posedge mclk) disable iff (srst)
      (instr_valid && dec.op == LON_NOR && dec.destination_register != 5'h00)
      |=> wb_valid && wb_data == ~($past(src_a) | $past(src_b));
   endproperty
   a_nor_result: assert property (p_nor_result)
      else $error("nor result wrong");

   property p_or_result;
      @(posedge mclk) disable iff (srst)
      (instr_valid && dec.op == LON_OR && dec.destination_register != 5'h00)
      |=> wb_valid && wb_data == ($past(src_a) | $past(src_b));
   endproperty
   a_or_result: assert property (p_or_result)
      else $error("or result wrong");

   property p_orhi_result;
      @(posedge mclk) disable iff (srst)
      (instr_valid && dec.op == LON_ORHI && dec.destination_register != 5'h00)
      |=> wb_data[15:0] == $past(src_a[15:0])
          && wb_data[31:16] == ($past(src_a[31:16]) | $past(instr[21:6]));
   endproperty
   a_orhi_result: assert property (p_orhi_result)
      else $error("orhi result wrong");

   property p_ori_result;
      @(posedge mclk) disable iff (srst)
      (instr_valid && dec.op == LON_ORI && dec.destination_register != 5'h00)
      |=> wb_data[31:16] == $past(src_a[31:16])
          && wb_data[15:0] == ($past(src_a[15:0]) | $past(instr[21:6]));
   endproperty
   a_ori_result: assert property (p_ori_result)
      else $error("ori result wrong");

   property p_ori_unsigned;
      @(posedge mclk) disable iff (srst)
      (instr_valid && dec.op == LON_ORI && src_a[31:16] == 16'h0000)
      |=> wb_data[31:16] == 16'h0000;
   endproperty
   a_ori_unsigned: assert property (p_ori_unsigned)
      else $error("ori immediate sign extended");

   property p_rtype_dest;
      @(posedge mclk) disable iff (srst)
      (instr_valid && (dec.op == LON_OR || dec.op == LON_NOR)
       && instr[21:17] != 5'h00)
      |=> wb_valid && wb_index == $past(instr[21:17]);
   endproperty
   a_rtype_dest: assert property (p_rtype_dest)
      else $error("r-type destination wrong");

   property p_itype_dest;
      @(posedge mclk) disable iff (srst)
      (instr_valid && (instr[5:0] == 6'h34 || instr[5:0] == 6'h14)
       && instr[26:22] != 5'h00)
      |=> wb_valid && wb_index == $past(instr[26:22]);
   endproperty
   a_itype_dest: assert property (p_itype_dest)
      else $error("i-type destination wrong");

   property p_nop_quiet;
      @(posedge mclk) disable iff (srst)
      (instr_valid && dec.op == LON_NOP) |=> !wb_valid && done_q;
   endproperty
   a_nop_quiet: assert property (p_nop_quiet)
      else $error("nop wrote state");

   property p_decode_map;
      @(posedge mclk) disable iff (srst)
      instr_valid && instr[5:0] == 6'h3a && instr[16:11] == 6'h16
      |-> dec.op == LON_OR;
   endproperty
   a_decode_map: assert property (p_decode_map)
      else $error("or not decoded");

   property p_no_exc;
      @(posedge mclk) disable iff (srst)
      instr_valid ##1 done_q |-> !exc_q;
   endproperty
   a_no_exc: assert property (p_no_exc)
      else $error("exception raised");

endmodule : lon_exec
`default_nettype wire

// ===== testbench/logical_or_nor_ops_tb.sv
// Self-checking testbench of the logical OR/NOR slice
`timescale 1ns/1ps
`default_nettype none
module logical_or_nor_ops_tb
   import lon_pkg::*;
;

   // ------------------------------------------------------------
   // Signals and register model
   // ------------------------------------------------------------
   logic mclk;
   logic srst;
   logic instr_valid;
   logic [31:0] instr;
   logic [4:0] rd_index;
   logic [31:0] rd_data;
   logic wb_valid;
   logic [4:0] wb_index;
   logic [31:0] wb_data;
   logic exc_q;
   logic done_q;
   logic [31:0] mdl [32];
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;

   lon_exec dut (.mclk(mclk), .srst(srst), .instr_valid(instr_valid),
      .instr(instr), .rd_index(rd_index), .rd_data(rd_data),
      .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data),
      .exc_q(exc_q), .done_q(done_q));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic end_of_test;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   function automatic logic [31:0] fr(logic [5:0] x, logic [4:0] a, b, c);
      return {a, b, c, x, 5'h00, OP_RTYPE};
   endfunction : fr

   function automatic logic [31:0] fi(logic [5:0] op, logic [4:0] a, b,
                                      logic [15:0] imm);
      return {a, b, imm, op};
   endfunction : fi

   // Expected {done, valid, index, data}; the model is updated as it goes
   function automatic logic [38:0] ex(logic [31:0] w);
      logic [4:0] a;
      logic [4:0] ix;
      logic [31:0] d;
      logic dn;
      a = w[31:27];
      ix = w[21:17];
      d = '0;
      dn = 1'b1;
      if (w[5:0] == OP_RTYPE && w[16:11] == XOP_NOR) begin
         d = ~(mdl[a] | mdl[w[26:22]]);
      end else if (w[5:0] == OP_RTYPE && w[16:11] == XOP_OR) begin
         d = mdl[a] | mdl[w[26:22]];
      end else if (w[5:0] == OP_ORHI || w[5:0] == OP_ORI) begin
         ix = w[26:22];
         d = mdl[a] | ((w[5:0] == OP_ORHI) ? {w[21:6], HALF_ZERO}
                                           : {HALF_ZERO, w[21:6]});
      end else begin
         ix = ZERO_REGISTER;
         dn = (w == fr(XOP_ADD, 5'h00, 5'h00, 5'h00));
      end
      if (dn && ix != ZERO_REGISTER) begin
         mdl[ix] = d;
      end
      return {dn, dn && ix != ZERO_REGISTER, ix, d};
   endfunction : ex

   task automatic cmp(input logic [38:0] e);
      chk("done_q", 32'(done_q), 32'(e[38]));
      chk("wb_valid", 32'(wb_valid), 32'(e[37]));
      if (e[37]) begin
         chk("wb_index", 32'(wb_index), 32'(e[36:32]));
         chk("wb_data", wb_data, e[31:0]);
      end
      chk("exc_q", 32'(exc_q), 32'h0000_0000);
   endtask : cmp

   // Called on an edge; results are sampled at the falling edge when settled
   task automatic go(input logic [31:0] w1, w2, input bit two);
      logic [38:0] e1;
      logic [38:0] e2;
      e1 = ex(w1);
      e2 = two ? ex(w2) : '0;
      instr <= w1;
      instr_valid <= 1'b1;
      @(posedge mclk);
      if (two) begin
         instr <= w2;
         @(negedge mclk);
         cmp(e1);
         @(posedge mclk);
         instr_valid <= 1'b0;
         @(negedge mclk);
         cmp(e2);
      end else begin
         instr_valid <= 1'b0;
         @(negedge mclk);
         cmp(e1);
      end
      @(posedge mclk);
   endtask : go

   task automatic rdreg(input logic [4:0] ix);
      rd_index <= ix;
      @(posedge mclk);
      @(negedge mclk);
      chk("rd_data", rd_data, mdl[ix]);
      @(posedge mclk);
   endtask : rdreg

   task automatic t_imm;
      go(fi(OP_ORHI, 5'd0, 5'd7, 16'h1234),
         fi(OP_ORI, 5'd7, 5'd7, 16'h8765), 1);
      go(fi(OP_ORI, 5'd0, 5'd8, 16'hF00F), '0, 0);
      go(fi(OP_ORHI, 5'd7, 5'd8, 16'h8000), '0, 0);
      rdreg(5'd8);
   endtask : t_imm

   task automatic t_reg;
      go(fr(XOP_OR, 5'd7, 5'd9, 5'd6), fr(XOP_NOR, 5'd6, 5'd8, 5'd9), 1);
      rdreg(5'd9);
   endtask : t_reg

   // nop, zero destination and foreign codes
   task automatic t_zero;
      go(fr(XOP_ADD, 5'd0, 5'd0, 5'd0), fr(XOP_OR, 5'd7, 5'd8, 5'd0), 1);
      go(fr(XOP_ADD, 5'd1, 5'd2, 5'd3), '0, 0);
      go(fi(OP_ADDI_UNUSED, 5'd7, 5'd6, 16'hFFFF), '0, 0);
      rdreg(5'd0);
      rdreg(5'd6);
   endtask : t_zero

   // Mid-run reset that meets a writing instruction: reset must win
   task automatic t_rst;
      instr <= fr(XOP_OR, 5'd7, 5'd8, 5'd5);
      instr_valid <= 1'b1;
      srst <= 1'b1;
      @(posedge mclk);
      instr_valid <= 1'b0;
      foreach (mdl[i]) mdl[i] = WORD_RESET;
      @(negedge mclk);
      chk("wb_valid", 32'(wb_valid), 32'h0000_0000);
      chk("done_q", 32'(done_q), 32'h0000_0000);
      @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      rdreg(5'd7);
      rdreg(5'd5);
   endtask : t_rst

   // ------------------------------------------------------------
   // Clock, timeout and main sequence
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Whole run needs well under a hundred cycles; the ceiling leaves margin
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         mismatches++;
         end_of_test();
      end
   end

   initial begin
      srst = 1'b1;
      instr_valid = 1'b0;
      instr = '0;
      rd_index = '0;
      foreach (mdl[i]) mdl[i] = WORD_RESET;
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      t_imm();
      t_reg();
      t_zero();
      t_rst();
      end_of_test();
   end

endmodule : logical_or_nor_ops_tb
`default_nettype wire
